// ### src/btsu_pkg.sv
package btsu_pkg;

    // instruction bytes and fields
    localparam logic [7:0] PFX_CB        = 8'hcb;
    localparam logic [7:0] PFX_IDX_FIRST = 8'hdd;
    localparam logic [7:0] PFX_IDX_SECOND = 8'hfd;
    localparam logic [1:0] GRP_TEST      = 2'h1;
    localparam logic [1:0] GRP_SET       = 2'h3;
    localparam logic [2:0] REG_FIELD_MEM = 3'h6;
    localparam int         GRP_HI        = 7;
    localparam int         GRP_LO        = 6;
    localparam int         BIT_HI        = 5;
    localparam int         BIT_LO        = 3;
    localparam int         REG_HI        = 2;
    localparam int         REG_LO        = 0;

    // register file slots, indexed by the register field
    localparam logic [2:0] REG_B         = 3'h0;
    localparam logic [2:0] REG_C         = 3'h1;
    localparam logic [2:0] REG_D         = 3'h2;
    localparam logic [2:0] REG_E         = 3'h3;
    localparam logic [2:0] REG_H         = 3'h4;
    localparam logic [2:0] REG_L         = 3'h5;
    localparam logic [2:0] REG_F_SLOT    = 3'h6;
    localparam logic [2:0] REG_A         = 3'h7;

    // flag bit positions
    localparam int FLAG_S  = 7;
    localparam int FLAG_Z  = 6;
    localparam int FLAG_H  = 4;
    localparam int FLAG_PV = 2;
    localparam int FLAG_N  = 1;
    localparam int FLAG_C  = 0;

    // clock states per machine cycle
    localparam logic [2:0] T_FETCH = 3'h4;
    localparam logic [2:0] T_DISP  = 3'h3;
    localparam logic [2:0] T_IDXOP = 3'h5;
    localparam logic [2:0] T_MEMRD = 3'h4;
    localparam logic [2:0] T_MEMWR = 3'h3;
    localparam logic [2:0] T_NONE  = 3'h1;

    // apb map, byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_BC     = 8'h08;
    localparam logic [7:0] ADDR_DE     = 8'h0c;
    localparam logic [7:0] ADDR_HL     = 8'h10;
    localparam logic [7:0] ADDR_AF     = 8'h14;
    localparam logic [7:0] ADDR_IDX1   = 8'h18;
    localparam logic [7:0] ADDR_IDX2   = 8'h1c;
    localparam logic [7:0] ADDR_TSTATE = 8'h20;
    localparam int         CTRL_START  = 0;
    localparam int         STAT_BUSY   = 0;
    localparam int         STAT_BAD    = 1;
    localparam int         STAT_DONE   = 2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PFX,
        ST_CB2,
        ST_DISP,
        ST_IDXOP,
        ST_OPC,
        ST_MEMRD,
        ST_MEMWR
    } btsu_state_t;

endpackage

// ### src/btsu_bit_alu.sv
`timescale 1ns/1ps
`default_nettype none

module btsu_bit_alu (
    input  wire logic [7:0] operand,
    input  wire logic [2:0] bit_sel,
    input  wire logic       do_set,
    input  wire logic [7:0] flags_in,
    output logic      [7:0] result,
    output logic      [7:0] flags_out
);

    // test or set one bit; only the test touches flags
    always_comb begin
        result    = operand;
        flags_out = flags_in;
        if (do_set) begin
            result[bit_sel] = 1'b1;
        end else begin
            flags_out[btsu_pkg::FLAG_Z] = ~operand[bit_sel];
            flags_out[btsu_pkg::FLAG_H] = 1'b1;
            flags_out[btsu_pkg::FLAG_N] = 1'b0;
        end
    end

endmodule // btsu_bit_alu

`default_nettype wire

// ### src/btsu_exec_unit.sv
// Behaviour
// - register bit test puts inverse of chosen bit into zero flag, register kept
// - bit field is binary bit number, 000 is bit 0 (lsb), 111 bit 7
// - register field 000..101 are B,C,D,E,H,L, 111 accumulator, 110 no register
// - test sets Z to inverted bit, H set, N cleared, C kept, S and P/V undefined
// - pointer-byte test is CB then 01 bbb 110
// - memory bit test only reads the byte, never writes it
// - indexed test is DD CB d 01bbb110 at first index plus signed d
// - FD prefix uses second index pair, same byte order and fields
// - indexed test takes 5 machine cycles, 20 states as 4,4,3,5,4
// - register bit set is CB then 11 bbb rrr, sets bit, flags unchanged
// - register bit set takes 8 states in two cycles of 4
// - pointer-byte set sets the bit, 4 cycles, 15 states, flags unchanged
// - indexed set on first index takes 6 cycles, 4,4,3,5,4,3 states
// - second-index set is FD CB d 11bbb110
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module btsu_exec_unit #(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [7:0]        op_byte,
    input  wire logic [7:0]        mem_rdata,
    output logic                   fetch_active,
    output logic                   mem_rd,
    output logic                   mem_wr,
    output logic      [15:0]       mem_addr,
    output logic      [7:0]        mem_wdata,
    output logic                   busy
);

    btsu_pkg::btsu_state_t state, next_state;
    logic [2:0]  tcnt, next_tcnt;
    logic [4:0]  ttot, next_ttot;
    logic [4:0]  tlast, next_tlast;
    logic [7:0]  gpr [0:7];
    logic [7:0]  next_gpr [0:7];
    logic [15:0] idx1, next_idx1;
    logic [15:0] idx2, next_idx2;
    logic        use_idx2, next_use_idx2;
    logic [7:0]  disp, next_disp;
    logic [7:0]  opcode, next_opcode;
    logic        bad, next_bad;
    logic        done, next_done;
    logic        next_busy;
    logic        next_fetch_active, next_mem_rd, next_mem_wr;
    logic [15:0] next_mem_addr;
    logic [7:0]  next_mem_wdata;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr;
    logic        last;
    logic        finish;
    logic [7:0]  cur_op;
    logic [7:0]  alu_operand, alu_result, alu_flags;
    logic [15:0] index_sel;

    // clock states of each machine cycle
    function automatic logic [2:0] cyc_len(input btsu_pkg::btsu_state_t s);
        case (s)
            btsu_pkg::ST_PFX,
            btsu_pkg::ST_CB2,
            btsu_pkg::ST_OPC:   cyc_len = btsu_pkg::T_FETCH;
            btsu_pkg::ST_DISP:  cyc_len = btsu_pkg::T_DISP;
            btsu_pkg::ST_IDXOP: cyc_len = btsu_pkg::T_IDXOP;
            btsu_pkg::ST_MEMRD: cyc_len = btsu_pkg::T_MEMRD;
            btsu_pkg::ST_MEMWR: cyc_len = btsu_pkg::T_MEMWR;
            default:            cyc_len = btsu_pkg::T_NONE;
        endcase
    endfunction

    // opcode group is one this unit executes
    function automatic logic grp_ok(input logic [7:0] op);
        grp_ok = (op[btsu_pkg::GRP_HI:btsu_pkg::GRP_LO] == btsu_pkg::GRP_TEST) ||
                 (op[btsu_pkg::GRP_HI:btsu_pkg::GRP_LO] == btsu_pkg::GRP_SET);
    endfunction

    function automatic logic grp_set(input logic [7:0] op);
        grp_set = (op[btsu_pkg::GRP_HI:btsu_pkg::GRP_LO] == btsu_pkg::GRP_SET);
    endfunction

    // addresses mapped to a register; any other address gets pslverr
    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        case (a[7:0])
            btsu_pkg::ADDR_CTRL, btsu_pkg::ADDR_STATUS, btsu_pkg::ADDR_BC,
            btsu_pkg::ADDR_DE, btsu_pkg::ADDR_HL, btsu_pkg::ADDR_AF,
            btsu_pkg::ADDR_IDX1, btsu_pkg::ADDR_IDX2,
            btsu_pkg::ADDR_TSTATE: addr_known = 1'b1;
            default:               addr_known = 1'b0;
        endcase
    endfunction

    // operand source: register file at opcode time, memory data at read time
    always_comb begin
        cur_op      = (state == btsu_pkg::ST_MEMRD) ? opcode : op_byte;
        alu_operand = (state == btsu_pkg::ST_MEMRD) ? mem_rdata
                                                    : gpr[op_byte[btsu_pkg::REG_HI:btsu_pkg::REG_LO]];
        index_sel   = use_idx2 ? idx2 : idx1;
    end

    btsu_bit_alu u_alu (
        .operand   (alu_operand),
        .bit_sel   (cur_op[btsu_pkg::BIT_HI:btsu_pkg::BIT_LO]),
        .do_set    (grp_set(cur_op)),
        .flags_in  (gpr[btsu_pkg::REG_F_SLOT]),
        .result    (alu_result),
        .flags_out (alu_flags)
    );

    // sequencer, register file and apb slave next values
    always_comb begin
        next_state    = state;
        next_tcnt     = tcnt;
        next_ttot     = ttot;
        next_tlast    = tlast;
        next_gpr      = gpr;
        next_idx1     = idx1;
        next_idx2     = idx2;
        next_use_idx2 = use_idx2;
        next_disp     = disp;
        next_opcode   = opcode;
        next_bad      = bad;
        next_done     = done;
        next_busy     = busy;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_prdata   = prdata;
        next_pready   = 1'b0;
        next_pslverr  = pslverr;
        finish        = 1'b0;
        last          = (tcnt == cyc_len(state) - 3'h1);

        // state counting
        if (state != btsu_pkg::ST_IDLE) begin
            next_tcnt = last ? 3'h0 : tcnt + 3'h1;
            next_ttot = ttot + 5'h01;
        end

        // machine cycle ends
        if (last) begin
            case (state)
                btsu_pkg::ST_PFX: begin
                    if (op_byte == btsu_pkg::PFX_CB) begin
                        next_state = btsu_pkg::ST_OPC;
                    end else if (op_byte == btsu_pkg::PFX_IDX_FIRST || op_byte == btsu_pkg::PFX_IDX_SECOND) begin
                        next_use_idx2 = (op_byte == btsu_pkg::PFX_IDX_SECOND);
                        next_state    = btsu_pkg::ST_CB2;
                    end else begin
                        next_bad = 1'b1;
                        finish   = 1'b1;
                    end
                end
                btsu_pkg::ST_CB2: begin
                    if (op_byte == btsu_pkg::PFX_CB) begin
                        next_state = btsu_pkg::ST_DISP;
                    end else begin
                        next_bad = 1'b1;
                        finish   = 1'b1;
                    end
                end
                btsu_pkg::ST_DISP: begin
                    next_disp  = op_byte;
                    next_state = btsu_pkg::ST_IDXOP;
                end
                btsu_pkg::ST_IDXOP: begin
                    if (grp_ok(op_byte) && op_byte[btsu_pkg::REG_HI:btsu_pkg::REG_LO] == btsu_pkg::REG_FIELD_MEM) begin
                        next_opcode   = op_byte;
                        next_mem_addr = index_sel + {{8{disp[7]}}, disp};
                        next_state    = btsu_pkg::ST_MEMRD;
                    end else begin
                        next_bad = 1'b1;
                        finish   = 1'b1;
                    end
                end
                btsu_pkg::ST_OPC: begin
                    if (!grp_ok(op_byte)) begin
                        next_bad = 1'b1;
                        finish   = 1'b1;
                    end else if (op_byte[btsu_pkg::REG_HI:btsu_pkg::REG_LO] == btsu_pkg::REG_FIELD_MEM) begin
                        next_opcode   = op_byte;
                        next_mem_addr = {gpr[btsu_pkg::REG_H], gpr[btsu_pkg::REG_L]};
                        next_state    = btsu_pkg::ST_MEMRD;
                    end else begin
                        finish = 1'b1;
                        if (grp_set(op_byte)) begin
                            next_gpr[op_byte[btsu_pkg::REG_HI:btsu_pkg::REG_LO]] = alu_result;
                        end else begin
                            next_gpr[btsu_pkg::REG_F_SLOT] = alu_flags;
                        end
                    end
                end
                btsu_pkg::ST_MEMRD: begin
                    if (grp_set(opcode)) begin
                        next_mem_wdata = alu_result;
                        next_state     = btsu_pkg::ST_MEMWR;
                    end else begin
                        next_gpr[btsu_pkg::REG_F_SLOT] = alu_flags;
                        finish = 1'b1;
                    end
                end
                btsu_pkg::ST_MEMWR: begin
                    finish = 1'b1;
                end
                default: begin
                    next_state = btsu_pkg::ST_IDLE;
                end
            endcase
        end

        // apb setup phase: decide answer
        if (psel && !penable) begin
            next_pready  = 1'b1;
            next_pslverr = !addr_known(paddr) ||
                           (pwrite && busy && paddr[7:0] != btsu_pkg::ADDR_CTRL &&
                            paddr[7:0] != btsu_pkg::ADDR_STATUS);
            case (paddr[7:0])
                btsu_pkg::ADDR_STATUS: next_prdata = {29'h0, done, bad, busy};
                btsu_pkg::ADDR_BC:     next_prdata = {16'h0, gpr[btsu_pkg::REG_B], gpr[btsu_pkg::REG_C]};
                btsu_pkg::ADDR_DE:     next_prdata = {16'h0, gpr[btsu_pkg::REG_D], gpr[btsu_pkg::REG_E]};
                btsu_pkg::ADDR_HL:     next_prdata = {16'h0, gpr[btsu_pkg::REG_H], gpr[btsu_pkg::REG_L]};
                btsu_pkg::ADDR_AF:     next_prdata = {16'h0, gpr[btsu_pkg::REG_A], gpr[btsu_pkg::REG_F_SLOT]};
                btsu_pkg::ADDR_IDX1:   next_prdata = {16'h0, idx1};
                btsu_pkg::ADDR_IDX2:   next_prdata = {16'h0, idx2};
                btsu_pkg::ADDR_TSTATE: next_prdata = {27'h0, tlast};
                default:               next_prdata = 32'h0;
            endcase
        end

        // apb access phase: writes take effect
        if (psel && penable && pready && pwrite && !pslverr) begin
            case (paddr[7:0])
                btsu_pkg::ADDR_CTRL: begin
                    if (pwdata[btsu_pkg::CTRL_START] && !busy) begin
                        next_busy  = 1'b1;
                        next_bad   = 1'b0;
                        next_state = btsu_pkg::ST_PFX;
                        next_tcnt  = 3'h0;
                        next_ttot  = 5'h00;
                    end
                end
                btsu_pkg::ADDR_STATUS: begin
                    if (pwdata[btsu_pkg::STAT_DONE]) begin
                        next_done = 1'b0;
                    end
                end
                btsu_pkg::ADDR_BC: begin
                    next_gpr[btsu_pkg::REG_B] = pwdata[15:8];
                    next_gpr[btsu_pkg::REG_C] = pwdata[7:0];
                end
                btsu_pkg::ADDR_DE: begin
                    next_gpr[btsu_pkg::REG_D] = pwdata[15:8];
                    next_gpr[btsu_pkg::REG_E] = pwdata[7:0];
                end
                btsu_pkg::ADDR_HL: begin
                    next_gpr[btsu_pkg::REG_H] = pwdata[15:8];
                    next_gpr[btsu_pkg::REG_L] = pwdata[7:0];
                end
                btsu_pkg::ADDR_AF: begin
                    next_gpr[btsu_pkg::REG_A]      = pwdata[15:8];
                    next_gpr[btsu_pkg::REG_F_SLOT] = pwdata[7:0];
                end
                btsu_pkg::ADDR_IDX1: next_idx1 = pwdata[15:0];
                btsu_pkg::ADDR_IDX2: next_idx2 = pwdata[15:0];
                default: begin
                    next_idx1 = idx1;
                end
            endcase
        end

        // instruction end; done set wins over a clear
        if (finish) begin
            next_state = btsu_pkg::ST_IDLE;
            next_tcnt  = 3'h0;
            next_busy  = 1'b0;
            next_done  = 1'b1;
            next_tlast = ttot + 5'h01;
        end

        // bus strobes follow the next state
        next_fetch_active = (next_state == btsu_pkg::ST_PFX) || (next_state == btsu_pkg::ST_CB2) ||
                            (next_state == btsu_pkg::ST_DISP) || (next_state == btsu_pkg::ST_IDXOP) ||
                            (next_state == btsu_pkg::ST_OPC);
        next_mem_rd       = (next_state == btsu_pkg::ST_MEMRD);
        next_mem_wr       = (next_state == btsu_pkg::ST_MEMWR);
    end

    // state registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state        <= btsu_pkg::ST_IDLE;
            tcnt         <= 3'h0;
            ttot         <= 5'h00;
            tlast        <= 5'h00;
            for (int i = 0; i < 8; i++) begin
                gpr[i] <= 8'h00;
            end
            idx1         <= 16'h0000;
            idx2         <= 16'h0000;
            use_idx2     <= 1'b0;
            disp         <= 8'h00;
            opcode       <= 8'h00;
            bad          <= 1'b0;
            done         <= 1'b0;
            busy         <= 1'b0;
            fetch_active <= 1'b0;
            mem_rd       <= 1'b0;
            mem_wr       <= 1'b0;
            mem_addr     <= 16'h0000;
            mem_wdata    <= 8'h00;
            prdata       <= 32'h0;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
        end else begin
            state        <= next_state;
            tcnt         <= next_tcnt;
            ttot         <= next_ttot;
            tlast        <= next_tlast;
            gpr          <= next_gpr;
            idx1         <= next_idx1;
            idx2         <= next_idx2;
            use_idx2     <= next_use_idx2;
            disp         <= next_disp;
            opcode       <= next_opcode;
            bad          <= next_bad;
            done         <= next_done;
            busy         <= next_busy;
            fetch_active <= next_fetch_active;
            mem_rd       <= next_mem_rd;
            mem_wr       <= next_mem_wr;
            mem_addr     <= next_mem_addr;
            mem_wdata    <= next_mem_wdata;
            prdata       <= next_prdata;
            pready       <= next_pready;
            pslverr      <= next_pslverr;
        end
    end

endmodule // btsu_exec_unit

`default_nettype wire

// ### test/btsu_exec_unit_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module btsu_exec_unit_asserts (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [7:0]  mem_rdata,
    input wire logic        fetch_active,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        busy
);
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    logic [4:0] busy_cnt;
    logic [4:0] next_busy_cnt;

    // counts states of the instruction in progress
    always_comb begin
        next_busy_cnt = busy ? busy_cnt + 5'h1 : 5'h0;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt <= 5'h0;
        end else begin
            busy_cnt <= next_busy_cnt;
        end
    end

    AST_PREADY_ONE: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single pulse after setup");
    AST_RD_LEN: assert property ($rose(mem_rd) |-> mem_rd [*4] ##1 !mem_rd)
        else $error("memory read cycle not four states");
    AST_WR_LEN: assert property ($rose(mem_wr) |-> mem_wr [*3] ##1 !mem_wr)
        else $error("memory write cycle not three states");
    AST_WR_AFTER_RD: assert property ($rose(mem_wr) |-> $past(mem_rd) && $stable(mem_addr))
        else $error("write not preceded by read of same address");
    AST_WR_ONEBIT: assert property ($rose(mem_wr) |-> (($past(mem_rdata) & ~mem_wdata) == 8'h00)
        && ($countones(mem_wdata ^ $past(mem_rdata)) <= 1))
        else $error("written byte differs from read byte by more than one set bit");
    AST_NO_OVERLAP: assert property (!(fetch_active && (mem_rd || mem_wr)) && !(mem_rd && mem_wr))
        else $error("machine cycles overlap");
    AST_ACT_IN_BUSY: assert property ((mem_rd || mem_wr || fetch_active) |-> busy)
        else $error("bus activity outside an instruction");
    AST_START_FETCH: assert property ($rose(busy) |-> fetch_active [*4])
        else $error("first fetch cycle not four states");
    AST_BUSY_MAX: assert property (busy |-> busy_cnt < 5'h17)
        else $error("instruction longer than 23 states");
    AST_ADDR_HOLD: assert property (mem_rd && $past(mem_rd) |-> $stable(mem_addr))
        else $error("address moved during read");
    AST_RD_AFTER_FETCH: assert property ($rose(mem_rd) |-> $past(fetch_active))
        else $error("read not right after opcode fetch");
endmodule // btsu_exec_unit_asserts

bind btsu_exec_unit btsu_exec_unit_asserts u_asserts (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
    .mem_rdata(mem_rdata), .fetch_active(fetch_active), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy)
);

`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic        fetch_active, mem_rd, mem_wr, busy;
    logic [7:0]  paddr, op_byte, mem_rdata, mem_wdata, mem_byte, wr_data;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] mem_addr, rd_addr, wr_addr;
    logic [7:0]  prog [4];
    logic [7:0]  m [8];
    int          fcnt, bcnt, rd_n, wr_n, bmark, rmark, wmark, n_mismatch, num_checks;

    btsu_exec_unit dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_byte(op_byte), .mem_rdata(mem_rdata), .fetch_active(fetch_active),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy));

    // fetch and memory stand-ins; lines show garbage when not in their cycle
    assign op_byte   = fetch_active ? prog[int'(fcnt >= 4) + int'(fcnt >= 8) + int'(fcnt >= 11)] : ~prog[0];
    assign mem_rdata = mem_rd ? mem_byte : ~mem_byte;

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // bus activity monitor
    always @(posedge ref_clk) begin
        fcnt <= busy ? fcnt + int'(fetch_active) : 0;
        bcnt <= bcnt + int'(busy);
        if (mem_rd) begin
            rd_n    <= rd_n + 1;
            rd_addr <= mem_addr;
        end
        if (mem_wr) begin
            wr_n    <= wr_n + 1;
            wr_addr <= mem_addr;
            wr_data <= mem_wdata;
        end
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n == 16) begin n_mismatch++; end_of_test(); end
    endtask

    function automatic logic [15:0] pv(input int p);
        return (p == 3) ? {m[7], m[6]} : {m[2*p], m[2*p+1]};
    endfunction

    task automatic regs(input logic wr);
        for (int p = 0; p < 4; p++) begin
            apb(wr, btsu_pkg::ADDR_BC + 8'(4*p), {16'h0, pv(p)});
            if (!wr) chk("pair", {16'h0, pv(p)}, q);
        end
    endtask

    task automatic go(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
        prog[0] <= a; prog[1] <= b; prog[2] <= c; prog[3] <= d;
        bmark = bcnt; rmark = rd_n; wmark = wr_n;
        apb(1'b1, btsu_pkg::ADDR_CTRL, 32'h1);
    endtask

    task automatic fin(input int st, input logic bad);
        int n;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (busy === 1'b0) break;
        end
        if (n == 100) begin n_mismatch++; end_of_test(); end
        if (st != 0) chk("busy_states", 32'(st), 32'(bcnt - bmark));
        apb(1'b0, btsu_pkg::ADDR_STATUS, 32'h0);
        chk("status", {29'h0, 1'b1, bad, 1'b0}, q);
        if (st != 0) begin
            apb(1'b0, btsu_pkg::ADDR_TSTATE, 32'h0);
            chk("tstate", 32'(st), q);
        end
        apb(1'b1, btsu_pkg::ADDR_STATUS, 32'h4);
    endtask

    task automatic flags(input logic tst, input logic bitv);
        if (tst) m[6] = (m[6] & 8'had) | {1'b0, ~bitv, 2'b01, 4'h0};
        apb(1'b0, btsu_pkg::ADDR_AF, 32'h0);
        chk("af", {16'h0, m[7], m[6]}, q);
    endtask

    task automatic memop(input logic [7:0] p0, p1, p2, p3, input logic [2:0] b, input logic tst,
                         input logic [7:0] mb, input logic [15:0] a, input int st);
        mem_byte <= mb;
        go(p0, p1, p2, p3);
        fin(st, 1'b0);
        chk("rd_addr", {16'h0, a}, {16'h0, rd_addr});
        chk("rd_states", 32'h4, 32'(rd_n - rmark));
        chk("wr_states", tst ? 32'h0 : 32'h3, 32'(wr_n - wmark));
        if (!tst) chk("wr", {a, 8'h0, mb | (8'h1 << b)}, {wr_addr, 8'h0, wr_data});
        flags(tst, mb[b]);
    endtask

    initial begin
        reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
        fcnt = 0; bcnt = 0; rd_n = 0; wr_n = 0; n_mismatch = 0; num_checks = 0;
        mem_byte = 8'h0; prog = '{8'h0, 8'h0, 8'h0, 8'h0};
        m = '{8'ha5, 8'h3c, 8'h0f, 8'hf0, 8'h81, 8'h7e, 8'h01, 8'h5a};
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        regs(1'b1);
        // every register code with every bit number
        for (int r = 0; r < 8; r++) begin
            for (int b = 0; b < 8; b++) begin
                if (r == 6) continue;
                go(btsu_pkg::PFX_CB, {btsu_pkg::GRP_TEST, 3'(b), 3'(r)}, 8'h0, 8'h0);
                fin(8, 1'b0);
                flags(1'b1, m[r][b]);
            end
        end
        regs(1'b0);
        for (int r = 0; r < 8; r++) begin
            for (int k = 0; k < 2; k++) begin
                if (r == 6) continue;
                go(btsu_pkg::PFX_CB, {btsu_pkg::GRP_SET, 3'(k ? 7 - r : r), 3'(r)}, 8'h0, 8'h0);
                fin(8, 1'b0);
                m[r][k ? 7 - r : r] = 1'b1;
            end
        end
        regs(1'b0);
        memop(8'hcb, 8'h66, 8'h0, 8'h0, 3'h4, 1'b1, 8'h10, pv(2), 12);
        memop(8'hcb, 8'h5e, 8'h0, 8'h0, 3'h3, 1'b1, 8'h10, pv(2), 12);
        memop(8'hcb, 8'hce, 8'h0, 8'h0, 3'h1, 1'b0, 8'h84, pv(2), 15);
        apb(1'b1, btsu_pkg::ADDR_IDX1, 32'hfffe);
        apb(1'b1, btsu_pkg::ADDR_IDX2, 32'h0010);
        memop(8'hdd, 8'hcb, 8'h05, 8'h76, 3'h6, 1'b1, 8'h40, 16'h0003, 20);
        memop(8'hfd, 8'hcb, 8'hf0, 8'h46, 3'h0, 1'b1, 8'hfe, 16'h0000, 20);
        memop(8'hdd, 8'hcb, 8'h80, 8'hd6, 3'h2, 1'b0, 8'h00, 16'hff7e, 23);
        memop(8'hfd, 8'hcb, 8'h7f, 8'hfe, 3'h7, 1'b0, 8'h7f, 16'h008f, 23);
        // undecodable bytes end the instruction with the bad flag
        go(8'h00, 8'h00, 8'h00, 8'h00);
        fin(0, 1'b1);
        go(btsu_pkg::PFX_CB, 8'h86, 8'h0, 8'h0);
        fin(0, 1'b1);
        go(btsu_pkg::PFX_IDX_FIRST, btsu_pkg::PFX_CB, 8'h00, 8'h40);
        fin(0, 1'b1);
        // register write refused while an instruction runs
        mem_byte <= 8'h55;
        go(btsu_pkg::PFX_CB, 8'hfe, 8'h0, 8'h0);
        apb(1'b1, btsu_pkg::ADDR_BC, 32'hffff);
        chk("busy_wr_err", 32'h1, {31'h0, err});
        fin(15, 1'b0);
        regs(1'b0);
        end_of_test();
    end
endmodule // tb

`default_nettype wire
